// File: sdlv_pkg.sv
package sdlv_pkg;

  // register offsets, as printed
  localparam logic [7:0] OFS_SD2_LOGIC = 8'h83;
  localparam logic [7:0] OFS_SD2_UPPER = 8'h84;
  localparam logic [7:0] OFS_SD2_LOWER = 8'h85;
  localparam logic [7:0] OFS_SD3_SOURCE = 8'h8c;
  localparam logic [7:0] OFS_SD3_LOGIC = 8'h8d;
  localparam logic [7:0] OFS_SD3_UPPER = 8'h8e;
  localparam logic [7:0] OFS_SD3_LOWER = 8'h8f;
  localparam logic [7:0] OFS_V1_DWELL = 8'h96;
  localparam logic [7:0] OFS_V1_DUTY = 8'h97;
  localparam logic [7:0] OFS_V2_DWELL = 8'h98;

  // reset values
  localparam logic [15:0] RST_LOGIC = 16'h0000;
  localparam logic [15:0] RST_UPPER = 16'h0001;
  localparam logic [15:0] RST_LOWER = 16'h0000;
  localparam logic [15:0] RST_SOURCE = 16'h0000;
  localparam logic [15:0] RST_DWELL = 16'h0005;
  localparam logic [15:0] RST_DUTY = 16'h0019;

  // trip-logic codes
  localparam logic [15:0] LOGIC_HIGH_ON = 16'h0000;
  localparam logic [15:0] LOGIC_HIGH_OFF = 16'h0001;
  localparam logic [15:0] LOGIC_WINDOW = 16'h0002;
  localparam logic [15:0] LOGIC_INV_WINDOW = 16'h0003;

  // input source codes
  localparam logic [15:0] SRC_NONE = 16'h0000;
  localparam logic [15:0] SRC_THERMOCOUPLE_ONE = 16'h0001;
  localparam logic [15:0] SRC_THERMOCOUPLE_TWO = 16'h0002;
  localparam logic [15:0] SRC_MODULE_THERMOCOUPLE = 16'h0003;
  localparam logic [15:0] SRC_TRANSDUCER = 16'h0004;
  localparam logic [15:0] SRC_PRESSURE_SWITCH_ONE = 16'h0005;
  localparam logic [15:0] SRC_PRESSURE_SWITCH_TWO = 16'h0006;

  // valve limits
  localparam logic [15:0] DWELL_MAX_S = 16'h000a;
  localparam logic [15:0] DUTY_MIN_PCT = 16'h0019;
  localparam logic [15:0] DUTY_MAX_PCT = 16'h0064;

  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int SECOND_S = 1;
  localparam int SECOND_CYCLES = CLK_HZ * SECOND_S;
  localparam int PWM_STEP_NS = 10_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int PWM_STEP_CYCLES = (PWM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : sdlv_pkg

// File: valve_if.sv
`timescale 1ns/100ps
interface valve_if;
  logic demand;
  logic [3:0] dwell_s;
  logic state;
  modport ctrl (output demand, output dwell_s, input state);
  modport valve (input demand, input dwell_s, output state);
endinterface : valve_if

// File: valve_dwell.sv
`timescale 1ns/100ps
module valve_dwell #(
  parameter int SECOND_CYCLES = sdlv_pkg::SECOND_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  valve_if.valve vif
);

  logic [31:0] cyc_cnt;
  logic [3:0] sec_cnt;
  logic held_enough;

  assign held_enough = (sec_cnt >= vif.dwell_s);

  // the output may only follow the demand once held for the dwell time
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vif.state <= 1'b0;
    end else if (vif.demand != vif.state && held_enough) begin
      vif.state <= vif.demand; // RULE_05
    end
  end

  // seconds since last change, saturating above the largest dwell
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc_cnt <= '0;
      sec_cnt <= '0;
    end else if (vif.demand != vif.state && held_enough) begin
      cyc_cnt <= '0; // RULE_05
      sec_cnt <= '0;
    end else if (cyc_cnt == 32'(SECOND_CYCLES - 1)) begin
      cyc_cnt <= '0;
      if (sec_cnt != 4'hf) begin
        sec_cnt <= sec_cnt + 4'h1;
      end
    end else begin
      cyc_cnt <= cyc_cnt + 32'h1;
    end
  end

endmodule : valve_dwell

// File: shutdown_limit_valve_config.sv
`timescale 1ns/100ps
// Operation
// RULE_01: each of shutdown channels 2 and 3 holds a signed 16-bit upper limit, reset to 1.
// RULE_02: each of shutdown channels 2 and 3 holds a signed 16-bit lower limit, reset to 0.
// RULE_03: trip logic codes are 0 high-on, 1 high-off, 2 window, 3 inverted window; reset 0.
// RULE_04: channel 3 source codes are 0 none through 6 second pressure switch; reset 0.
// RULE_05: a process valve output is held in a new state for the dwell, 0 to 10 s, default 5.
// RULE_06: the process 1 valve runs PWM at a duty of 25 to 100 percent, default 25.
// RULE_07: high-on trips above upper and clears below lower, windows trip inside or outside.
module shutdown_limit_valve_config #(
  parameter int SECOND_CYCLES = sdlv_pkg::SECOND_CYCLES,
  parameter int PWM_STEP_CYCLES = sdlv_pkg::PWM_STEP_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_ack,
  input wire logic [15:0] i_shutdown2_input_select,
  input wire logic [15:0] i_thermocouple_one,
  input wire logic [15:0] i_thermocouple_two,
  input wire logic [15:0] i_module_thermocouple,
  input wire logic [15:0] i_transducer_input,
  input wire logic [15:0] i_pressure_switch_one,
  input wire logic [15:0] i_pressure_switch_two,
  input wire logic i_valve1_demand,
  input wire logic i_valve2_demand,
  output logic o_shutdown2_trip,
  output logic o_shutdown3_trip,
  output logic o_valve1,
  output logic o_valve2
);

  ////////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_n;
  logic rst_n;

  // two stages so the release never lands near a clock edge
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register file

  logic [15:0] shutdown2_trip_logic;
  logic [15:0] shutdown2_upper_limit;
  logic [15:0] shutdown2_lower_limit;
  logic [15:0] shutdown3_input_select;
  logic [15:0] shutdown3_trip_logic;
  logic [15:0] shutdown3_upper_limit;
  logic [15:0] shutdown3_lower_limit;
  logic [15:0] valve1_min_dwell;
  logic [15:0] valve1_pwm_duty;
  logic [15:0] valve2_min_dwell;
  logic [15:0] next_rdata;

  // writes store the value as given; range limits are applied where used
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shutdown2_trip_logic <= sdlv_pkg::RST_LOGIC; // RULE_03
      shutdown2_upper_limit <= sdlv_pkg::RST_UPPER; // RULE_01
      shutdown2_lower_limit <= sdlv_pkg::RST_LOWER; // RULE_02
      shutdown3_input_select <= sdlv_pkg::RST_SOURCE; // RULE_04
      shutdown3_trip_logic <= sdlv_pkg::RST_LOGIC; // RULE_03
      shutdown3_upper_limit <= sdlv_pkg::RST_UPPER; // RULE_01
      shutdown3_lower_limit <= sdlv_pkg::RST_LOWER; // RULE_02
      valve1_min_dwell <= sdlv_pkg::RST_DWELL; // RULE_05
      valve1_pwm_duty <= sdlv_pkg::RST_DUTY; // RULE_06
      valve2_min_dwell <= sdlv_pkg::RST_DWELL; // RULE_05
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        sdlv_pkg::OFS_SD2_LOGIC: shutdown2_trip_logic <= i_reg_wdata;
        sdlv_pkg::OFS_SD2_UPPER: shutdown2_upper_limit <= i_reg_wdata;
        sdlv_pkg::OFS_SD2_LOWER: shutdown2_lower_limit <= i_reg_wdata;
        sdlv_pkg::OFS_SD3_SOURCE: shutdown3_input_select <= i_reg_wdata;
        sdlv_pkg::OFS_SD3_LOGIC: shutdown3_trip_logic <= i_reg_wdata;
        sdlv_pkg::OFS_SD3_UPPER: shutdown3_upper_limit <= i_reg_wdata;
        sdlv_pkg::OFS_SD3_LOWER: shutdown3_lower_limit <= i_reg_wdata;
        sdlv_pkg::OFS_V1_DWELL: valve1_min_dwell <= i_reg_wdata;
        sdlv_pkg::OFS_V1_DUTY: valve1_pwm_duty <= i_reg_wdata;
        sdlv_pkg::OFS_V2_DWELL: valve2_min_dwell <= i_reg_wdata;
        default: ; // unused and unmapped offsets ignore writes
      endcase
    end
  end

  // read mux; unused offsets read as zero
  always_comb begin
    case (i_reg_addr)
      sdlv_pkg::OFS_SD2_LOGIC: next_rdata = shutdown2_trip_logic;
      sdlv_pkg::OFS_SD2_UPPER: next_rdata = shutdown2_upper_limit;
      sdlv_pkg::OFS_SD2_LOWER: next_rdata = shutdown2_lower_limit;
      sdlv_pkg::OFS_SD3_SOURCE: next_rdata = shutdown3_input_select;
      sdlv_pkg::OFS_SD3_LOGIC: next_rdata = shutdown3_trip_logic;
      sdlv_pkg::OFS_SD3_UPPER: next_rdata = shutdown3_upper_limit;
      sdlv_pkg::OFS_SD3_LOWER: next_rdata = shutdown3_lower_limit;
      sdlv_pkg::OFS_V1_DWELL: next_rdata = valve1_min_dwell;
      sdlv_pkg::OFS_V1_DUTY: next_rdata = valve1_pwm_duty;
      sdlv_pkg::OFS_V2_DWELL: next_rdata = valve2_min_dwell;
      default: next_rdata = 16'h0000;
    endcase
  end

  // answer one cycle after the strobe; read data holds until the next read
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata <= 16'h0000;
      o_reg_ack <= 1'b0;
    end else begin
      o_reg_ack <= i_reg_wr | i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shutdown channels

  function automatic logic [15:0] pick_source(input logic [15:0] sel);
    case (sel)
      sdlv_pkg::SRC_THERMOCOUPLE_ONE: pick_source = i_thermocouple_one; // RULE_04
      sdlv_pkg::SRC_THERMOCOUPLE_TWO: pick_source = i_thermocouple_two;
      sdlv_pkg::SRC_MODULE_THERMOCOUPLE: pick_source = i_module_thermocouple;
      sdlv_pkg::SRC_TRANSDUCER: pick_source = i_transducer_input;
      sdlv_pkg::SRC_PRESSURE_SWITCH_ONE: pick_source = i_pressure_switch_one;
      sdlv_pkg::SRC_PRESSURE_SWITCH_TWO: pick_source = i_pressure_switch_two;
      default: pick_source = 16'h0000;
    endcase
  endfunction : pick_source

  logic [15:0] ch_sel [2];
  logic [15:0] ch_logic [2];
  logic [15:0] ch_upper [2];
  logic [15:0] ch_lower [2];
  logic [1:0] ch_trip;

  assign ch_sel[0] = i_shutdown2_input_select;
  assign ch_sel[1] = shutdown3_input_select;
  assign ch_logic[0] = shutdown2_trip_logic;
  assign ch_logic[1] = shutdown3_trip_logic;
  assign ch_upper[0] = shutdown2_upper_limit;
  assign ch_upper[1] = shutdown3_upper_limit;
  assign ch_lower[0] = shutdown2_lower_limit;
  assign ch_lower[1] = shutdown3_lower_limit;

  // the same comparator pair for each channel; codes beyond 6 act as none
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic signed [15:0] value;
    logic above;
    logic below;
    logic enabled;
    logic trip;

    // one driver per channel; the flag vector is only a wiring point
    assign ch_trip[c] = trip;
    assign value = $signed(pick_source(ch_sel[c]));
    assign above = value > $signed(ch_upper[c]); // RULE_01
    assign below = value < $signed(ch_lower[c]); // RULE_02
    assign enabled = (ch_sel[c] != sdlv_pkg::SRC_NONE) &&
                     (ch_sel[c] <= sdlv_pkg::SRC_PRESSURE_SWITCH_TWO);

    // hysteresis modes keep state between the limits, windows are direct
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        trip <= 1'b0;
      end else if (!enabled) begin
        trip <= 1'b0; // RULE_07
      end else begin
        case (ch_logic[c])
          sdlv_pkg::LOGIC_HIGH_ON: begin // RULE_03
            if (above) begin
              trip <= 1'b1; // RULE_07
            end else if (below) begin
              trip <= 1'b0;
            end
          end
          sdlv_pkg::LOGIC_HIGH_OFF: begin
            if (below) begin
              trip <= 1'b1; // RULE_07
            end else if (above) begin
              trip <= 1'b0;
            end
          end
          sdlv_pkg::LOGIC_WINDOW: trip <= !above && !below; // RULE_07
          sdlv_pkg::LOGIC_INV_WINDOW: trip <= above || below; // RULE_07
          default: trip <= 1'b0;
        endcase
      end
    end
  end

  assign o_shutdown2_trip = ch_trip[0];
  assign o_shutdown3_trip = ch_trip[1];

  ////////////////////////////////////////////////////////////////////////////////
  // process valves

  valve_if v1_if ();
  valve_if v2_if ();

  // dwell above the documented maximum is held at the maximum
  function automatic logic [3:0] clamp_dwell(input logic [15:0] d);
    clamp_dwell = (d > sdlv_pkg::DWELL_MAX_S) ? sdlv_pkg::DWELL_MAX_S[3:0] : d[3:0];
  endfunction : clamp_dwell

  assign v1_if.demand = i_valve1_demand;
  assign v1_if.dwell_s = clamp_dwell(valve1_min_dwell); // RULE_05
  assign v2_if.demand = i_valve2_demand;
  assign v2_if.dwell_s = clamp_dwell(valve2_min_dwell); // RULE_05

  valve_dwell #(.SECOND_CYCLES(SECOND_CYCLES)) u_valve1 (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .vif(v1_if.valve)
  );

  valve_dwell #(.SECOND_CYCLES(SECOND_CYCLES)) u_valve2 (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .vif(v2_if.valve)
  );

  // pwm: 100 steps per period, one step per prescaler wrap
  logic [15:0] pwm_pre;
  logic [6:0] pwm_step;
  logic [15:0] duty_eff;

  assign duty_eff = (valve1_pwm_duty < sdlv_pkg::DUTY_MIN_PCT) ? sdlv_pkg::DUTY_MIN_PCT :
                    (valve1_pwm_duty > sdlv_pkg::DUTY_MAX_PCT) ? sdlv_pkg::DUTY_MAX_PCT :
                    valve1_pwm_duty; // RULE_06

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwm_pre <= 16'h0000;
      pwm_step <= 7'h00;
    end else if (pwm_pre == 16'(PWM_STEP_CYCLES - 1)) begin
      pwm_pre <= 16'h0000;
      pwm_step <= (pwm_step == 7'(sdlv_pkg::DUTY_MAX_PCT - 1)) ? 7'h00 : pwm_step + 7'h01;
    end else begin
      pwm_pre <= pwm_pre + 16'h0001;
    end
  end

  // only the dwell-filtered state is chopped, so dwell timing is unaffected
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_valve1 <= 1'b0;
      o_valve2 <= 1'b0;
    end else begin
      o_valve1 <= v1_if.state && ({9'h000, pwm_step} < duty_eff); // RULE_06
      o_valve2 <= v2_if.state;
    end
  end

endmodule : shutdown_limit_valve_config

// File: sdlv_monitor.sv
`timescale 1ns/100ps
module sdlv_monitor #(
  parameter int SECOND_CYCLES = sdlv_pkg::SECOND_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_reg_ack,
  input wire logic [15:0] i_shutdown2_input_select,
  input wire logic i_valve2_demand,
  input wire logic o_shutdown2_trip,
  input wire logic o_shutdown3_trip,
  input wire logic o_valve1,
  input wire logic o_valve2
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////////
  // shadow of the valve 2 dwell; clamp to 10 s as the design uses it
  logic [15:0] dwell2;
  int cnt2;
  int lim2;
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) dwell2 <= 16'h0005;
    else if (i_reg_wr && i_reg_addr == 8'h98) dwell2 <= i_reg_wdata;
  end
  // cycles since the last output change; counts from our reset, so never short
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) cnt2 <= 0;
    else if ($changed(o_valve2)) cnt2 <= 0;
    else if (cnt2 < 15 * SECOND_CYCLES) cnt2 <= cnt2 + 1;
  end
  assign lim2 = ((dwell2 > 16'h000a) ? 10 : int'(dwell2)) * SECOND_CYCLES;
  ////////////////////////////////////////////////////////////////////////////
  sequence s_req;
    i_reg_wr || i_reg_rd;
  endsequence
  sequence s_ans;
    o_reg_ack;
  endsequence
  property p_ack;
    s_req |=> s_ans;
  endproperty
  property p_ack_cause;
    o_reg_ack |-> $past(i_reg_wr || i_reg_rd);
  endproperty
  property p_rdata_hold;
    $changed(o_reg_rdata) |-> $past(i_reg_rd);
  endproperty
  property p_quiet;
    $rose(i_rstn) |-> !o_reg_ack && !o_valve1 && !o_valve2 && !o_shutdown2_trip
      && !o_shutdown3_trip;
  endproperty
  property p_trip2_off;
    (i_shutdown2_input_select == 16'h0000 || i_shutdown2_input_select > 16'h0006)
      |=> !o_shutdown2_trip;
  endproperty
  property p_v2_follow;
    $changed(o_valve2) |-> o_valve2 == $past(i_valve2_demand, 2);
  endproperty
  property p_v2_dwell;
    $changed(o_valve2) |-> cnt2 >= lim2 - 2;
  endproperty
  a_ack: assert property (p_ack) else $error("strobe not acked");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
  a_quiet: assert property (p_quiet) else $error("outputs active in reset");
  a_trip2_off: assert property (p_trip2_off) else $error("disabled trip");
  a_v2_follow: assert property (p_v2_follow) else $error("valve2 wrong");
  a_v2_dwell: assert property (p_v2_dwell) else $error("valve2 dwell short");
endmodule : sdlv_monitor

// File: sdlv_host.sv
`timescale 1ns/100ps
module sdlv_host (
  input wire logic i_clk_sys,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [15:0] o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 16'h0000;
  end
  // one-cycle strobe, then the fixed one-cycle answer; bus inverted once released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    o_wr <= w;
    o_rd <= !w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    @(posedge i_clk_sys);
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask : xfer
endmodule : sdlv_host

// File: tb.sv
`timescale 1ns/100ps
module tb;
  logic clk, rstn, wr, rd, ack, v1d, v2d, trip2, trip3, v1, v2, e;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, sel2, d;
  logic [15:0] sens [6];
  logic [16:0] note;
  logic [16:0] notes [$];
  int n_fail, tests_run, cnt;
  logic [7:0] ofs [10] = '{8'h83, 8'h84, 8'h85, 8'h8c, 8'h8d, 8'h8e, 8'h8f, 8'h96, 8'h97, 8'h98};
  logic [15:0] rstv [10] = '{16'h0, 16'h1, 16'h0, 16'h0, 16'h0, 16'h1, 16'h0, 16'h5, 16'h19, 16'h5};
  int vals [6] = '{200, 100, 0, -200, -100, 0};
  logic [15:0] duty [5] = '{16'h19, 16'h32, 16'h64, 16'h0a, 16'h96};
  logic [15:0] ons [5] = '{16'h32, 16'h64, 16'hc8, 16'h32, 16'hc8};
  ////////////////////////////////////////////////////////////////////////////
  sdlv_host u_sdlv_host (.i_clk_sys(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  shutdown_limit_valve_config #(.SECOND_CYCLES(20), .PWM_STEP_CYCLES(2))
    u_shutdown_limit_valve_config (.i_clk_sys(clk), .i_rstn(rstn), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_ack(ack), .i_shutdown2_input_select(sel2), .i_thermocouple_one(sens[0]),
    .i_thermocouple_two(sens[1]), .i_module_thermocouple(sens[2]),
    .i_transducer_input(sens[3]), .i_pressure_switch_one(sens[4]),
    .i_pressure_switch_two(sens[5]), .i_valve1_demand(v1d), .i_valve2_demand(v2d),
    .o_shutdown2_trip(trip2), .o_shutdown3_trip(trip3), .o_valve1(v1), .o_valve2(v2));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk_word(input string n, input logic [15:0] x, input logic [15:0] g);
    tests_run++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask : chk_word
  task automatic chk_bit(input string n, input logic x, input logic g);
    tests_run++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", n, x, g);
    end
  endtask : chk_bit
  // every access leaves a note; reads carry the value expected back
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    notes.push_back({1'b0, 16'h0000});
    u_sdlv_host.xfer(1'b1, a, v);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] x);
    notes.push_back({1'b1, x});
    u_sdlv_host.xfer(1'b0, a, 16'h0000);
  endtask : rd_reg
  // hysteresis modes keep the previous verdict between the limits
  function automatic logic ef(int m, int v, logic p);
    case (m)
      0: ef = (v > 100) ? 1'b1 : ((v < -100) ? 1'b0 : p);
      1: ef = (v < -100) ? 1'b1 : ((v > 100) ? 1'b0 : p);
      2: ef = (v >= -100) && (v <= 100);
      default: ef = (v < -100) || (v > 100);
    endcase
  endfunction : ef
  task automatic end_sim;
    chk_word("pending notes", 16'h0000, 16'(notes.size()));
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  // answers are matched to the oldest note as the ack shows
  always @(posedge clk) begin
    if (ack === 1'b1) begin
      if (notes.size() == 0) begin
        chk_bit("ack", 1'b0, ack);
      end else begin
        note = notes.pop_front();
        if (note[16]) chk_word("rdata", note[15:0], rdata);
      end
    end
  end
  initial begin
    #1_000_000;
    n_fail++;
    end_sim();
  end
  initial begin
    rstn = 1'b0;
    v1d = 1'b0;
    v2d = 1'b0;
    sel2 = 16'h0000;
    foreach (sens[i]) sens[i] = 16'h0000;
    void'($urandom(32'hf5d8));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 10; i++) rd_reg(ofs[i], rstv[i]);
    rd_reg(8'h86, 16'h0000);
    $display("reset values done");
    for (int i = 0; i < 10; i++) begin
      d = 16'($urandom);
      wr_reg(ofs[i], d);
      rd_reg(ofs[i], d);
    end
    wr_reg(8'h90, 16'hffff);
    rd_reg(8'h90, 16'h0000);
    $display("readback done");
    wr_reg(8'h84, 16'h0064);
    wr_reg(8'h85, 16'hff9c);
    wr_reg(8'h8e, 16'h0064);
    wr_reg(8'h8f, 16'hff9c);
    e = 1'b0;
    for (int m = 0; m < 4; m++) begin
      wr_reg(8'h83, 16'(m));
      wr_reg(8'h8d, 16'(m));
      for (int s = 0; s < 8; s++) begin
        wr_reg(8'h8c, 16'(s));
        sel2 <= 16'(s);
        foreach (vals[k]) begin
          @(posedge clk);
          for (int j = 0; j < 6; j++) sens[j] <= (j == s - 1) ? 16'(vals[k]) : 16'($urandom);
          repeat (3) @(posedge clk);
          e = (s == 0 || s == 7) ? 1'b0 : ef(m, vals[k], e);
          chk_bit("trip2", e, trip2);
          chk_bit("trip3", e, trip3);
        end
      end
    end
    $display("trip logic done");
    wr_reg(8'h98, 16'h0002);
    @(posedge clk);
    v2d <= 1'b1;
    repeat (3) @(posedge clk);
    chk_bit("valve2 on", 1'b1, v2);
    v2d <= 1'b0;
    repeat (30) @(posedge clk);
    chk_bit("valve2 held", 1'b1, v2);
    repeat (20) @(posedge clk);
    chk_bit("valve2 off", 1'b0, v2);
    wr_reg(8'h98, 16'h0000);
    @(posedge clk);
    v2d <= 1'b1;
    repeat (3) @(posedge clk);
    chk_bit("valve2 zero dwell", 1'b1, v2);
    $display("dwell done");
    @(posedge clk);
    v1d <= 1'b1;
    foreach (duty[i]) begin
      wr_reg(8'h97, duty[i]);
      repeat (4) @(posedge clk);
      cnt = 0;
      repeat (200) begin
        @(posedge clk);
        cnt += int'(v1);
      end
      chk_word("valve1 on count", ons[i], 16'(cnt));
    end
    $display("pwm done");
    end_sim();
  end
endmodule : tb
bind shutdown_limit_valve_config sdlv_monitor #(.SECOND_CYCLES(SECOND_CYCLES)) u_sdlv_monitor (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_reg_ack(o_reg_ack), .i_shutdown2_input_select(i_shutdown2_input_select),
  .i_valve2_demand(i_valve2_demand), .o_shutdown2_trip(o_shutdown2_trip),
  .o_shutdown3_trip(o_shutdown3_trip), .o_valve1(o_valve1), .o_valve2(o_valve2));
